// file: common/bft_consts.svh
`ifndef BFT_CONSTS_SVH
`define BFT_CONSTS_SVH

// Register byte offsets
`define BFT_OFF_CTRL      12'h000
`define BFT_OFF_PHTHR     12'h004
`define BFT_OFF_RESTHR    12'h008
`define BFT_OFF_RETRIP    12'h00C
`define BFT_OFF_BFTIME    12'h010
`define BFT_OFF_SIGMASK   12'h014
`define BFT_OFF_DOMASK    12'h018
`define BFT_OFF_STATUS    12'h01C
`define BFT_OFF_PHA       12'h020
`define BFT_OFF_PHB       12'h024
`define BFT_OFF_PHC       12'h028
`define BFT_OFF_RES       12'h02C
`define BFT_OFF_PREFAULT  12'h030
`define BFT_OFF_CNT_START 12'h034
`define BFT_OFF_CNT_RETR  12'h038
`define BFT_OFF_CNT_BF    12'h03C
`define BFT_OFF_CNT_BLK   12'h040
`define BFT_OFF_CNTCLR    12'h044
`define BFT_OFF_EVENT     12'h048
`define BFT_OFF_GROUP     12'h04C

// Control fields
`define BFT_CTRL_MODE_LSB   0
`define BFT_CTRL_RSEL_LSB   4
`define BFT_CTRL_NODE_LSB   8
`define BFT_CTRL_FEN_BIT    11
`define BFT_CTRL_FST_LSB    12
`define BFT_CTRL_RTEN_BIT   15

// Reset values
`define BFT_RST_MODE    4'h0
`define BFT_RST_RSEL    2'h0
`define BFT_RST_NODE    3'h1
`define BFT_RST_FST     3'h0
`define BFT_RST_PHTHR   16'h0014
`define BFT_RST_RESTHR  16'h04B0
`define BFT_RST_RETRIP  18'h0_0014
`define BFT_RST_BFTIME  18'h0_0028

// Timing
`define BFT_CLK_HZ      200000000
`define BFT_TICK_MS     5
`define BFT_STAMP_MS    1
`define BFT_AVG_MS      20
`define BFT_HYST_NUM    97
`define BFT_HYST_DEN    100

`endif

// file: common/bft_pkg.sv
package bft_pkg;
	typedef enum logic [3:0] {
		BFT_M_CUR        = 4'h0,
		BFT_M_DO         = 4'h1,
		BFT_M_SIG        = 4'h2,
		BFT_M_CUR_AND_DO = 4'h3,
		BFT_M_CUR_OR_DO  = 4'h4,
		BFT_M_CUR_AND_SG = 4'h5,
		BFT_M_CUR_OR_SG  = 4'h6,
		BFT_M_SG_AND_DO  = 4'h7,
		BFT_M_SG_OR_DO   = 4'h8,
		BFT_M_ANY        = 4'h9,
		BFT_M_ALL        = 4'hA
	} bft_mode_t;

	typedef enum logic [2:0] {
		BFT_N_ON      = 3'h1,
		BFT_N_BLOCKED = 3'h2,
		BFT_N_TEST    = 3'h3,
		BFT_N_TESTBLK = 3'h4,
		BFT_N_OFF     = 3'h5
	} bft_node_t;

	typedef enum logic [2:0] {
		BFT_F_NORMAL  = 3'h0,
		BFT_F_START   = 3'h1,
		BFT_F_RETRIP  = 3'h2,
		BFT_F_BFTRIP  = 3'h3,
		BFT_F_BLOCKED = 3'h4
	} bft_force_t;

	typedef enum logic [3:0] {
		BFT_S_IDLE    = 4'b0001,
		BFT_S_BLOCKED = 4'b0010,
		BFT_S_TIMING  = 4'b0100,
		BFT_S_FAILED  = 4'b1000
	} bft_state_t;
endpackage

// file: tb/bft_meas_model.sv
`timescale 1ns/1ps
`default_nettype none
module bft_meas_model #(
	parameter int PER = 50
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic [15:0] want [6],
	output logic      [15:0] mag  [6]
);
	int cnt;
	// RMS values refreshed once per time base
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt <= 0;
			mag <= '{default: 16'h0000};
		end else if (cnt == PER - 1) begin
			cnt <= 0;
			mag <= want;
		end else
			cnt <= cnt + 1;
	end
endmodule
`default_nettype wire

// file: tb/bft_top_sva.sv
`timescale 1ns/1ps
`default_nettype none
module bft_top_chk #(
	parameter int CLK_HZ = 10000
) (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        failure_start,
	input wire logic        second_coil_trip,
	input wire logic        breaker_fail_trip,
	input wire logic        blocked,
	input wire logic        force_enable_in
);
	localparam int TICK = CLK_HZ / 1000 * 5;
	logic [3:0]  outs;
	logic [3:0]  outs_r;
	logic [31:0] gap_r;
	assign outs = {blocked, breaker_fail_trip, second_coil_trip, failure_start};
	// Cycles since any output last moved
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			outs_r <= 4'h0;
			gap_r  <= 32'h0000_0000;
		end else begin
			outs_r <= outs;
			gap_r  <= (outs != outs_r) ? 32'h0000_0000 : gap_r + 1;
		end
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_ready; psel && penable |-> pready; endproperty
	a_ready: assert property (p_ready) else $error("pready low in access");
	property p_err; pslverr |-> psel && penable; endproperty
	a_err: assert property (p_err) else $error("pslverr outside access");
	property p_rdata; psel && penable |=> $stable(prdata); endproperty
	a_rdata: assert property (p_rdata) else $error("read data moved after access");
	property p_excl; !(failure_start && blocked); endproperty
	a_excl: assert property (p_excl) else $error("start while blocked");
	property p_gap; outs != outs_r |-> gap_r >= TICK - 1; endproperty
	a_gap: assert property (p_gap) else $error("outputs moved between ticks");
	property p_bf; $rose(breaker_fail_trip) && !force_enable_in |-> $past(failure_start); endproperty
	a_bf: assert property (p_bf) else $error("trip without start");
	property p_sc; $rose(second_coil_trip) && !force_enable_in |-> failure_start; endproperty
	a_sc: assert property (p_sc) else $error("retrip without start");
	property p_rel;
		$fell(failure_start) && !force_enable_in |-> !breaker_fail_trip && !second_coil_trip;
	endproperty
	a_rel: assert property (p_rel) else $error("timers kept after release");
	c_blk: cover property (blocked);
	c_bf: cover property ($rose(breaker_fail_trip));
	c_err: cover property (pslverr);
endmodule
bind bft_top bft_top_chk #(.CLK_HZ(CLK_HZ)) u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.failure_start(failure_start), .second_coil_trip(second_coil_trip),
	.breaker_fail_trip(breaker_fail_trip), .blocked(blocked), .force_enable_in(force_enable_in));
`default_nettype wire

// file: tb/tb_breaker_failure_trigger.sv
`timescale 1ns/1ps
`default_nettype none
`include "bft_consts.svh"
module tb_breaker_failure_trigger;
	localparam int HZ = 10000;
	localparam int TK = HZ / 1000 * 5;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, ser;
	logic        st, rt, bf, bk, blk, fen;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q, rnd;
	logic [15:0] want [6];
	logic [15:0] mag  [6];
	logic [7:0]  relay;
	logic [15:0] sig;
	logic [2:0]  grp;
	logic [3:0]  outs;
	int          fail_count, samples_checked, n;
	assign outs = {bk, bf, rt, st};
	bft_top #(.CLK_HZ(HZ)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .phase_a_rms(mag[0]), .phase_b_rms(mag[1]),
		.phase_c_rms(mag[2]), .first_residual_input(mag[3]), .second_residual_input(mag[4]),
		.calculated_residual(mag[5]), .output_relay_status_in(relay),
		.binary_input_status_in(sig), .block_in(blk), .force_enable_in(fen),
		.group_select_in(grp), .failure_start(st), .second_coil_trip(rt),
		.breaker_fail_trip(bf), .blocked(bk));
	bft_meas_model #(.PER(TK)) u_meas (.pclk(pclk), .presetn(presetn), .want(want), .mag(mag));
	initial begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {1'b0, x[31:1]} ^ (x[0] ? 32'h8020_0003 : 32'h0000_0000);
	endfunction
	function automatic logic [31:0] cw(input int m, r, k, f);
		return 32'h0000_8000 | 32'(m) | 32'(r) << 4 | 32'(k) << 8 | 32'(f) << 12;
	endfunction
	function automatic logic mexp(input int m, input logic c, d, s);
		case (m)
			0: return c;
			1: return d;
			2: return s;
			3: return c & d;
			4: return c | d;
			5: return c & s;
			6: return c | s;
			7: return s & d;
			8: return s | d;
			9: return c | d | s;
			10: return c & d & s;
			default: return 1'b0;
		endcase
	endfunction
	task automatic chk(input logic [31:0] got, exp, input string m);
		samples_checked++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] %0t %s", $time, m);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] v);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= v;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		q = prdata;
		ser = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rdc(input logic [11:0] a, input logic [31:0] e, input string m);
		apb(1'b0, a, 32'h0000_0000);
		chk(q, e, m);
	endtask
	task automatic tk(input int k);
		repeat (k * TK) @(posedge pclk);
	endtask
	task automatic finish_test;
		if (fail_count == 0 && samples_checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial begin
		{psel, penable, pwrite, paddr, pwdata, relay, sig, blk, fen, grp} = '0;
		presetn = 1'b0;
		want = '{default: 16'h0000};
		rnd = 32'he5b5_9b01;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, `BFT_OFF_CTRL, 32'h0000_0000);
		chk(q & 32'h0000_7FFF, 32'h0000_0100, "ctrl reset");
		rdc(`BFT_OFF_PHTHR, 32'h0000_0014, "phase thr reset");
		rdc(`BFT_OFF_RESTHR, 32'h0000_04B0, "resid thr reset");
		apb(1'b0, 12'h0FC, 32'h0000_0000);
		chk({q[31:1], ser}, 32'h0000_0001, "unmapped");
		grp <= 3'h1;
		repeat (4) @(posedge pclk);
		apb(1'b1, `BFT_OFF_PHTHR, 32'h0000_0033);
		grp <= 3'h0;
		repeat (4) @(posedge pclk);
		rdc(`BFT_OFF_PHTHR, 32'h0000_0014, "group");
		apb(1'b1, `BFT_OFF_PHTHR, 32'h0000_0064);
		apb(1'b1, `BFT_OFF_RESTHR, 32'h0000_00C8);
		apb(1'b1, `BFT_OFF_RETRIP, 32'h0000_0002);
		apb(1'b1, `BFT_OFF_BFTIME, 32'h0000_0008);
		apb(1'b1, `BFT_OFF_SIGMASK, 32'h0000_0001);
		apb(1'b1, `BFT_OFF_DOMASK, 32'h0000_0001);
		apb(1'b1, `BFT_OFF_CTRL, cw(0, 0, 1, 0));
		want[1] <= 16'h0065;
		n = 0;
		while (st !== 1'b1 && n < 4) begin
			tk(1);
			n++;
		end
		tk(4);
		chk(32'(outs), 32'h0000_0003, "retrip");
		tk(6);
		chk(32'(outs), 32'h0000_0007, "trip");
		apb(1'b1, `BFT_OFF_CTRL, 32'h0000_0100);
		tk(2);
		chk(32'(outs), 32'h0000_0005, "retrip off");
		apb(1'b1, `BFT_OFF_CTRL, cw(0, 0, 1, 0));
		want[1] <= 16'h0061;
		tk(3);
		chk(32'(outs), 32'h0000_0007, "hysteresis");
		blk <= 1'b1;
		tk(3);
		chk(32'(outs), 32'h0000_0008, "late block");
		want[1] <= 16'h0060;
		blk <= 1'b0;
		tk(5);
		chk(32'(outs), 32'h0000_0000, "release");
		apb(1'b1, `BFT_OFF_RETRIP, 32'h0000_0064);
		apb(1'b1, `BFT_OFF_BFTIME, 32'h0000_00C8);
		for (int r = 0; r < 4; r++) begin
			for (int k = 1; k < 4; k++) begin
				apb(1'b1, `BFT_OFF_CTRL, cw(0, r, 1, 0));
				want[2 + k] <= 16'h00C9;
				tk(5);
				chk(32'(st), 32'(r == k), "residual");
				want[2 + k] <= 16'h0000;
			end
		end
		for (int m = 0; m < 12; m++) begin
			repeat (3) begin
				rnd = lfsr(rnd);
				apb(1'b1, `BFT_OFF_CTRL, cw(m, 0, 1, 0));
				want[0] <= rnd[0] ? 16'h0065 + rnd[12:8] : {11'h000, rnd[12:8]};
				relay <= {rnd[23:17], rnd[1]};
				sig <= {rnd[31:17], rnd[2]};
				tk(5);
				chk(32'(st), 32'(mexp(m, rnd[0], rnd[1], rnd[2])), "mode");
			end
		end
		want[0] <= 16'h00C8;
		relay <= 8'h00;
		sig <= 16'h0000;
		for (int k = 1; k < 6; k++) begin
			if (k == 3) begin
				want[0] <= 16'h0000;
				tk(5);
				want[0] <= 16'h00C8;
			end
			apb(1'b1, `BFT_OFF_CTRL, cw(0, 0, k, 0));
			tk(5);
			chk(32'({bk, st}), 32'({k == 2 || k == 4, k == 1 || k == 3}), "node");
		end
		want[0] <= 16'h0000;
		fen <= 1'b1;
		for (int f = 0; f < 5; f++) begin
			apb(1'b1, `BFT_OFF_CTRL, cw(0, 0, 1, f));
			tk(5);
			chk(32'(f ? outs[f - 1] : |outs), 32'(f != 0), "force");
		end
		fen <= 1'b0;
		apb(1'b1, `BFT_OFF_CTRL, cw(0, 0, 1, 0));
		tk(3);
		apb(1'b0, `BFT_OFF_CNT_START, 32'h0000_0000);
		chk(32'(q == 32'h0000_0000), 32'h0000_0000, "count");
		apb(1'b1, `BFT_OFF_CNTCLR, 32'h0000_000F);
		rdc(`BFT_OFF_CNT_START, 32'h0000_0000, "count clear");
		rdc(`BFT_OFF_CNT_BLK, 32'h0000_0000, "count clear");
		apb(1'b0, `BFT_OFF_EVENT, 32'h0000_0000);
		chk(32'(q[31:28]), 32'(outs), "event");
		finish_test;
	end
	initial begin
		repeat (60000) @(posedge pclk);
		fail_count++;
		finish_test;
	end
endmodule
`default_nettype wire

// file: verilog/bft_cmp.sv
`timescale 1ns/1ps
`default_nettype none
`include "bft_consts.svh"

module bft_cmp #(
	parameter int W = 16
) (
	input  wire logic         pclk,
	input  wire logic         presetn,
	input  wire logic         tick,
	input  wire logic [W-1:0] mag,
	input  wire logic [W-1:0] thr,
	output logic              pick
);
	// Release when mag*100 < thr*97
	wire [W+7:0] mag_s = (W+8)'(mag) * (W+8)'(`BFT_HYST_DEN);
	wire [W+7:0] rel_s = (W+8)'(thr) * (W+8)'(`BFT_HYST_NUM);
	wire         above = (mag > thr);
	wire         below = (mag_s < rel_s);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pick <= 1'b0;
		end else if (tick) begin
			if (above) begin
				pick <= 1'b1;
			end else if (below) begin
				pick <= 1'b0;
			end
		end
	end
endmodule

`default_nettype wire

// file: verilog/bft_tick.sv
`timescale 1ns/1ps
`default_nettype none
`include "bft_consts.svh"

module bft_tick #(
	parameter int CLK_HZ = `BFT_CLK_HZ,
	parameter int TICK_MS = `BFT_TICK_MS,
	parameter int STAMP_MS = `BFT_STAMP_MS
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	output logic             tick_eval,
	output logic             tick_ms,
	output logic [31:0]      stamp_ms
);
	localparam int MS_CYC = (CLK_HZ / 1000) * STAMP_MS;

	logic [31:0] div_r;
	logic [7:0]  ms_r;
	wire         ms_hit  = (div_r == 32'(MS_CYC - 1));
	wire         ev_hit  = ms_hit && (ms_r == 8'(TICK_MS - 1));

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_r     <= 32'h0000_0000;
			ms_r      <= 8'h00;
			stamp_ms  <= 32'h0000_0000;
			tick_ms   <= 1'b0;
			tick_eval <= 1'b0;
		end else begin
			div_r     <= ms_hit ? 32'h0000_0000 : div_r + 32'h0000_0001;
			tick_ms   <= ms_hit;
			tick_eval <= ev_hit;
			if (ms_hit) begin
				ms_r     <= ev_hit ? 8'h00 : ms_r + 8'h01;
				stamp_ms <= stamp_ms + 32'h0000_0001;
			end
		end
	end
endmodule

`default_nettype wire

// file: verilog/bft_top.sv
// The implementer's own choices: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "bft_consts.svh"

// What this block does
// - Decode eleven-value trigger mode code
// - Select residual source: none, first, second, calculated
// - Release pick-up below 97 percent threshold
// - Common phase threshold, any phase or residual
// - Phase threshold steps 0.01 In, default 0.20
// - Residual threshold steps 0.001 In, default 1.200
// - Start only when pick-up and not blocked
// - Signal trigger picks up same evaluation
// - Inputs refreshed on 5 ms time base
// - Pre-fault value is 20 ms average
// - Thresholds compare RMS magnitudes only
// - Node behaviour mode one to five, default on
// - Forced status codes when forcing enabled
// - Signal triggers only in signal modes
// - Output relay triggers only in relay modes
// - ON/OFF events with 1 ms stamps
// - Resettable counters for start, retrip, trip, blocked
// - Eight setting groups from one source
// - Four outputs: start, retrip, trip, blocked
// - Relay mode watches selected relay status
// - Second coil retrip can be disabled
// - One pick-up starts both timers, 5 ms steps
// - Late blocking withdraws start like release
// - Timers reset when pick-up falls
module bft_top #(
	parameter int MW = 16,
	parameter int NSIG = 16,
	parameter int NDO = 8,
	parameter int CLK_HZ = `BFT_CLK_HZ
) (
	input  wire logic            pclk,
	input  wire logic            presetn,
	input  wire logic            psel,
	input  wire logic            penable,
	input  wire logic            pwrite,
	input  wire logic [11:0]     paddr,
	input  wire logic [31:0]     pwdata,
	output logic      [31:0]     prdata,
	output logic                 pready,
	output logic                 pslverr,
	input  wire logic [MW-1:0]   phase_a_rms,
	input  wire logic [MW-1:0]   phase_b_rms,
	input  wire logic [MW-1:0]   phase_c_rms,
	input  wire logic [MW-1:0]   first_residual_input,
	input  wire logic [MW-1:0]   second_residual_input,
	input  wire logic [MW-1:0]   calculated_residual,
	input  wire logic [NDO-1:0]  output_relay_status_in,
	input  wire logic [NSIG-1:0] binary_input_status_in,
	input  wire logic            block_in,
	input  wire logic            force_enable_in,
	input  wire logic [2:0]      group_select_in,
	output logic                 failure_start,
	output logic                 second_coil_trip,
	output logic                 breaker_fail_trip,
	output logic                 blocked
);
	localparam int NG = 8;

	// Synchronised external levels
	logic [NDO-1:0]  do_s1_r, do_s2_r;
	logic [NSIG-1:0] di_s1_r, di_s2_r;
	logic            blk_s1_r, blk_s2_r, fen_s1_r, fen_s2_r;
	logic [2:0]      grp_s1_r, grp_s2_r;
	logic [MW-1:0]   pa_s1_r, pb_s1_r, pc_s1_r, r1_s1_r, r2_s1_r, rc_s1_r;
	logic [MW-1:0]   pa_r, pb_r, pc_r, r1_r, r2_r, rc_r;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			{do_s1_r, do_s2_r} <= '0;
			{di_s1_r, di_s2_r} <= '0;
			{blk_s1_r, blk_s2_r, fen_s1_r, fen_s2_r} <= 4'h0;
			{grp_s1_r, grp_s2_r} <= 6'h00;
			{pa_s1_r, pb_s1_r, pc_s1_r, r1_s1_r, r2_s1_r, rc_s1_r} <= '0;
			{pa_r, pb_r, pc_r, r1_r, r2_r, rc_r} <= '0;
		end else begin
			do_s1_r  <= output_relay_status_in;
			do_s2_r  <= do_s1_r;
			di_s1_r  <= binary_input_status_in;
			di_s2_r  <= di_s1_r;
			blk_s1_r <= block_in;
			blk_s2_r <= blk_s1_r;
			fen_s1_r <= force_enable_in;
			fen_s2_r <= fen_s1_r;
			grp_s1_r <= group_select_in;
			grp_s2_r <= grp_s1_r;
			pa_s1_r  <= phase_a_rms;
			pa_r     <= pa_s1_r;
			pb_s1_r  <= phase_b_rms;
			pb_r     <= pb_s1_r;
			pc_s1_r  <= phase_c_rms;
			pc_r     <= pc_s1_r;
			r1_s1_r  <= first_residual_input;
			r1_r     <= r1_s1_r;
			r2_s1_r  <= second_residual_input;
			r2_r     <= r2_s1_r;
			rc_s1_r  <= calculated_residual;
			rc_r     <= rc_s1_r;
		end
	end

	// Time base
	logic        tick, tick_ms;
	logic [31:0] stamp;

	bft_tick #(.CLK_HZ(CLK_HZ)) u_tick (
		.pclk      (pclk),
		.presetn   (presetn),
		.tick_eval (tick),
		.tick_ms   (tick_ms),
		.stamp_ms  (stamp)
	);

	// Static settings
	logic [2:0]      node_r, fst_r;
	logic [1:0]      rsel_r;
	logic [NSIG-1:0] sigmask_r;
	logic [NDO-1:0]  domask_r;
	logic [2:0]      grp_r;

	// Per-group settings
	logic [3:0]  g_mode_r   [NG];
	logic        g_rten_r   [NG];
	logic [15:0] g_phthr_r  [NG];
	logic [15:0] g_resthr_r [NG];
	logic [17:0] g_retr_r   [NG];
	logic [17:0] g_bf_r     [NG];

	// APB decode
	wire wr_en = psel && penable && pwrite;
	wire rd_en = psel && penable && !pwrite;
	wire a_ctrl   = (paddr == `BFT_OFF_CTRL);
	wire a_phthr  = (paddr == `BFT_OFF_PHTHR);
	wire a_resthr = (paddr == `BFT_OFF_RESTHR);
	wire a_retr   = (paddr == `BFT_OFF_RETRIP);
	wire a_bf     = (paddr == `BFT_OFF_BFTIME);
	wire a_sig    = (paddr == `BFT_OFF_SIGMASK);
	wire a_do     = (paddr == `BFT_OFF_DOMASK);
	wire a_clr    = (paddr == `BFT_OFF_CNTCLR);
	wire a_grp    = (paddr == `BFT_OFF_GROUP);
	logic        mapped;
	logic [31:0] rd_mux;
	assign pready  = 1'b1;
	assign pslverr = psel && penable && !mapped;

	// Active group follows external selection
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			grp_r <= 3'h0;
		end else begin
			grp_r <= grp_s2_r;
		end
	end

	wire [2:0]  wg = grp_r;
	wire        wr_ctrl = wr_en && a_ctrl;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			node_r    <= `BFT_RST_NODE;
			fst_r     <= `BFT_RST_FST;
			rsel_r    <= `BFT_RST_RSEL;
			sigmask_r <= '0;
			domask_r  <= '0;
		end else if (wr_en) begin
			if (a_ctrl) begin
				node_r <= pwdata[`BFT_CTRL_NODE_LSB +: 3];
				fst_r  <= pwdata[`BFT_CTRL_FST_LSB +: 3];
				rsel_r <= pwdata[`BFT_CTRL_RSEL_LSB +: 2];
			end
			if (a_sig) sigmask_r <= pwdata[NSIG-1:0];
			if (a_do) domask_r <= pwdata[NDO-1:0];
		end
	end

	for (genvar g = 0; g < NG; g++) begin : g_grp
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				g_mode_r[g]   <= `BFT_RST_MODE;
				g_rten_r[g]   <= 1'b1;
				g_phthr_r[g]  <= `BFT_RST_PHTHR;
				g_resthr_r[g] <= `BFT_RST_RESTHR;
				g_retr_r[g]   <= `BFT_RST_RETRIP;
				g_bf_r[g]     <= `BFT_RST_BFTIME;
			end else if (wr_en && (wg == 3'(g))) begin
				if (a_ctrl) begin
					g_mode_r[g] <= pwdata[`BFT_CTRL_MODE_LSB +: 4];
					g_rten_r[g] <= pwdata[`BFT_CTRL_RTEN_BIT];
				end
				if (a_phthr) g_phthr_r[g] <= pwdata[15:0];
				if (a_resthr) g_resthr_r[g] <= pwdata[15:0];
				if (a_retr) g_retr_r[g] <= pwdata[17:0];
				if (a_bf) g_bf_r[g] <= pwdata[17:0];
			end
		end
	end

	wire [3:0]  mode   = g_mode_r[grp_r];
	wire        rt_en  = g_rten_r[grp_r];
	wire [15:0] phthr  = g_phthr_r[grp_r];
	wire [15:0] resthr = g_resthr_r[grp_r];

	// Residual source
	wire [MW-1:0] res_mag = (rsel_r == 2'h1) ? r1_r :
	                        (rsel_r == 2'h2) ? r2_r :
	                        (rsel_r == 2'h3) ? rc_r : '0;

	// Current comparators on RMS values
	logic [3:0] pk;
	wire [MW-1:0] mags [4];
	assign mags[0] = pa_r;
	assign mags[1] = pb_r;
	assign mags[2] = pc_r;
	assign mags[3] = res_mag;
	for (genvar c = 0; c < 4; c++) begin : g_cmp
		bft_cmp #(.W(MW)) u_cmp (
			.pclk    (pclk),
			.presetn (presetn),
			.tick    (tick),
			.mag     (mags[c]),
			.thr     (c == 3 ? MW'(resthr) : MW'(phthr)),
			.pick    (pk[c])
		);
	end
	wire cur_pk = (|pk[2:0]) || (pk[3] && (rsel_r != 2'h0));

	// Trigger sources
	logic [NDO-1:0]  do_t_r;
	logic [NSIG-1:0] di_t_r;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			do_t_r <= '0;
			di_t_r <= '0;
		end else if (tick) begin
			do_t_r <= do_s2_r;
			di_t_r <= di_s2_r;
		end
	end
	wire do_pk  = |(do_s2_r & domask_r);
	wire sig_pk = |(di_s2_r & sigmask_r);

	logic trig;
	always_comb begin
		case (mode)
			bft_pkg::BFT_M_CUR:        trig = cur_pk;
			bft_pkg::BFT_M_DO:         trig = do_pk;
			bft_pkg::BFT_M_SIG:        trig = sig_pk;
			bft_pkg::BFT_M_CUR_AND_DO: trig = cur_pk && do_pk;
			bft_pkg::BFT_M_CUR_OR_DO:  trig = cur_pk || do_pk;
			bft_pkg::BFT_M_CUR_AND_SG: trig = cur_pk && sig_pk;
			bft_pkg::BFT_M_CUR_OR_SG:  trig = cur_pk || sig_pk;
			bft_pkg::BFT_M_SG_AND_DO:  trig = sig_pk && do_pk;
			bft_pkg::BFT_M_SG_OR_DO:   trig = sig_pk || do_pk;
			bft_pkg::BFT_M_ANY:        trig = cur_pk || do_pk || sig_pk;
			bft_pkg::BFT_M_ALL:        trig = cur_pk && do_pk && sig_pk;
			default:                   trig = 1'b0;
		endcase
	end

	// Node mode and blocking
	wire node_off = (node_r == bft_pkg::BFT_N_OFF);
	wire node_blk = (node_r == bft_pkg::BFT_N_BLOCKED) || (node_r == bft_pkg::BFT_N_TESTBLK);
	wire blk_now  = blk_s2_r || node_blk;

	// Evaluation state machine
	bft_pkg::bft_state_t st_r, st_nxt;
	logic [17:0] retr_cnt_r, bf_cnt_r;
	wire retr_done = (retr_cnt_r >= g_retr_r[grp_r]);
	wire bf_done   = (bf_cnt_r >= g_bf_r[grp_r]);

	always_comb begin
		case (st_r)
			bft_pkg::BFT_S_IDLE:
				st_nxt = !trig ? bft_pkg::BFT_S_IDLE :
				         blk_now ? bft_pkg::BFT_S_BLOCKED : bft_pkg::BFT_S_TIMING;
			bft_pkg::BFT_S_BLOCKED:
				st_nxt = trig ? bft_pkg::BFT_S_BLOCKED : bft_pkg::BFT_S_IDLE;
			bft_pkg::BFT_S_TIMING:
				st_nxt = !trig ? bft_pkg::BFT_S_IDLE :
				         blk_now ? bft_pkg::BFT_S_BLOCKED :
				         bf_done ? bft_pkg::BFT_S_FAILED : bft_pkg::BFT_S_TIMING;
			bft_pkg::BFT_S_FAILED:
				st_nxt = !trig ? bft_pkg::BFT_S_IDLE :
				         blk_now ? bft_pkg::BFT_S_BLOCKED : bft_pkg::BFT_S_FAILED;
			default:
				st_nxt = bft_pkg::BFT_S_IDLE;
		endcase
	end

	wire timing = (st_nxt == bft_pkg::BFT_S_TIMING) || (st_nxt == bft_pkg::BFT_S_FAILED);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r       <= bft_pkg::BFT_S_IDLE;
			retr_cnt_r <= 18'h0_0000;
			bf_cnt_r   <= 18'h0_0000;
		end else if (tick) begin
			st_r <= node_off ? bft_pkg::BFT_S_IDLE : st_nxt;
			if (timing && !node_off) begin
				retr_cnt_r <= retr_done ? retr_cnt_r : retr_cnt_r + 18'h0_0001;
				bf_cnt_r   <= bf_done ? bf_cnt_r : bf_cnt_r + 18'h0_0001;
			end else begin
				retr_cnt_r <= 18'h0_0000;
				bf_cnt_r   <= 18'h0_0000;
			end
		end
	end

	// Outputs, with forcing
	wire in_time = (st_r == bft_pkg::BFT_S_TIMING) || (st_r == bft_pkg::BFT_S_FAILED);
	wire fon     = fen_s2_r && (fst_r != bft_pkg::BFT_F_NORMAL);
	wire o_start = fon ? (fst_r == bft_pkg::BFT_F_START) : in_time;
	wire o_retr  = fon ? (fst_r == bft_pkg::BFT_F_RETRIP) : (in_time && retr_done && rt_en);
	wire o_bf    = fon ? (fst_r == bft_pkg::BFT_F_BFTRIP) : (st_r == bft_pkg::BFT_S_FAILED);
	wire o_blk   = fon ? (fst_r == bft_pkg::BFT_F_BLOCKED) : (st_r == bft_pkg::BFT_S_BLOCKED);
	wire [3:0] o_vec = {o_blk, o_bf, o_retr, o_start};
	wire [3:0] cur_vec = {blocked, breaker_fail_trip, second_coil_trip, failure_start};
	wire [3:0] rise = o_vec & ~cur_vec;
	wire [3:0] chg  = o_vec ^ cur_vec;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			failure_start     <= 1'b0;
			second_coil_trip  <= 1'b0;
			breaker_fail_trip <= 1'b0;
			blocked           <= 1'b0;
		end else if (tick) begin
			{blocked, breaker_fail_trip, second_coil_trip, failure_start} <= o_vec;
		end
	end

	// Event record and counters
	logic [31:0] ev_r;
	logic [15:0] cnt_r [4];
	wire clr_wr = wr_en && a_clr;
	for (genvar k = 0; k < 4; k++) begin : g_cnt
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				cnt_r[k] <= 16'h0000;
			end else if (tick && rise[k]) begin
				cnt_r[k] <= cnt_r[k] + 16'h0001;
			end else if (clr_wr && pwdata[k]) begin
				cnt_r[k] <= 16'h0000;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ev_r <= 32'h0000_0000;
		end else if (tick && (|chg)) begin
			ev_r <= {o_vec, chg, stamp[23:0]};
		end
	end

	// Pre-fault average, 20 ms window ending 20 ms back
	localparam int NAVG = `BFT_AVG_MS / `BFT_TICK_MS;
	logic [MW-1:0] hist_r [2*NAVG-1];
	logic [MW-1:0] pref_r;
	logic [MW+1:0] hsum;
	always_comb begin
		hsum = '0;
		for (int i = NAVG - 1; i < 2 * NAVG - 1; i++) hsum = hsum + (MW+2)'(hist_r[i]);
	end
	wire [MW-1:0] pmax = (pa_r > pb_r) ? ((pa_r > pc_r) ? pa_r : pc_r)
	                                   : ((pb_r > pc_r) ? pb_r : pc_r);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < 2 * NAVG - 1; i++) hist_r[i] <= '0;
			pref_r <= '0;
		end else if (tick) begin
			hist_r[0] <= pmax;
			for (int i = 1; i < 2 * NAVG - 1; i++) hist_r[i] <= hist_r[i-1];
			if (rise[0] || rise[2]) pref_r <= MW'(hsum >> 2);
		end
	end

	// Read mux
	always_comb begin
		mapped = 1'b1;
		case (paddr)
			`BFT_OFF_CTRL:      rd_mux = {16'h0000, rt_en, fst_r, 1'b0, node_r, 2'h0, rsel_r, mode};
			`BFT_OFF_PHTHR:     rd_mux = {16'h0000, phthr};
			`BFT_OFF_RESTHR:    rd_mux = {16'h0000, resthr};
			`BFT_OFF_RETRIP:    rd_mux = {14'h0000, g_retr_r[grp_r]};
			`BFT_OFF_BFTIME:    rd_mux = {14'h0000, g_bf_r[grp_r]};
			`BFT_OFF_SIGMASK:   rd_mux = 32'(sigmask_r);
			`BFT_OFF_DOMASK:    rd_mux = 32'(domask_r);
			`BFT_OFF_STATUS:    rd_mux = {20'h0_0000, st_r, pk, o_vec};
			`BFT_OFF_PHA:       rd_mux = 32'(pa_r);
			`BFT_OFF_PHB:       rd_mux = 32'(pb_r);
			`BFT_OFF_PHC:       rd_mux = 32'(pc_r);
			`BFT_OFF_RES:       rd_mux = 32'(res_mag);
			`BFT_OFF_PREFAULT:  rd_mux = 32'(pref_r);
			`BFT_OFF_CNT_START: rd_mux = {16'h0000, cnt_r[0]};
			`BFT_OFF_CNT_RETR:  rd_mux = {16'h0000, cnt_r[1]};
			`BFT_OFF_CNT_BF:    rd_mux = {16'h0000, cnt_r[2]};
			`BFT_OFF_CNT_BLK:   rd_mux = {16'h0000, cnt_r[3]};
			`BFT_OFF_CNTCLR:    rd_mux = 32'h0000_0000;
			`BFT_OFF_EVENT:     rd_mux = ev_r;
			`BFT_OFF_GROUP:     rd_mux = {29'h0000_0000, grp_r};
			default: begin
				rd_mux = 32'h0000_0000;
				mapped = 1'b0;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (psel && !penable && !pwrite) begin
			prdata <= rd_mux;
		end
	end

	wire unused_ok = &{1'b0, rd_en, wr_ctrl, a_grp, do_t_r, di_t_r, tick_ms, stamp[31:24]};
endmodule

`default_nettype wire
